// ### testbench/dac_aux_cfg_monitor.sv
// Checker for the aux, reference and calibration register slice.
// Sees only the top module ports; attached by bind from the bench.
`timescale 1ns/1ps
module dac_aux_cfg_monitor
(
  input wire logic                          sys_clk,
  input wire logic                          rst,
  input wire logic                          csb_n,
  input wire logic                          sdio_oe,
  input wire logic [5:0]                    cal_address1_value,
  input wire dac_aux_cfg_pkg::aux_channel_s aux_i,
  input wire dac_aux_cfg_pkg::aux_channel_s aux_q,
  input wire logic [5:0]                    reference_trim_code,
  input wire dac_aux_cfg_pkg::cal_setup_s   cal_setup,
  input wire logic                          cal_clock_gate,
  input wire logic [2:0]                    cal_clock_divider,
  input wire logic                          cal_clock
);
  import dac_aux_cfg_pkg::*;
  // ****************************************
  // Half period tracking
  // ****************************************
  logic       prev_clk;
  logic [2:0] prev_div;
  logic [8:0] run;
  logic       clean;

  // Runs that straddle a gate or divider change are partial, so skip them
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      prev_clk <= 1'b0;
      prev_div <= 3'h0;
      run      <= 9'h000;
      clean    <= 1'b0;
    end
    else
    begin
      prev_clk <= cal_clock;
      prev_div <= cal_clock_divider;
      run      <= (cal_clock != prev_clk) ? 9'h001 : run + 9'h001;
      clean    <= (cal_clock != prev_clk) | clean;
      if (!cal_clock_gate || cal_clock_divider != prev_div)
        clean <= 1'b0;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ****************************************
  // Assertions
  // ****************************************
  // divided half period
  // The counter sees a new ratio one cycle before the registered divider port does
  AST_CAL_HALF: assert property ((cal_clock != prev_clk) && clean && cal_clock_gate
    && cal_clock_divider == prev_div |-> run == (9'h080 >> cal_clock_divider))
    else $error("cal clock half period wrong");
  AST_GATE_OFF: assert property (!cal_clock_gate && $past(!cal_clock_gate) |-> !cal_clock)
    else $error("cal clock runs while gated");
  AST_RISE_GATED: assert property ($rose(cal_clock) |-> cal_clock_gate)
    else $error("cal clock rose without gate");
  AST_Q_PRELOAD: assert property (!$past(rst) && $stable(cal_setup.q_preload_source) && $stable(cal_address1_value)
    |-> cal_setup.q_preload_reference == (cal_setup.q_preload_source ? cal_address1_value : PRELOAD_FIXED))
    else $error("q preload reference wrong");
  AST_I_PRELOAD: assert property (!$past(rst) && $stable(cal_setup.i_preload_source) && $stable(cal_address1_value)
    |-> cal_setup.i_preload_reference == (cal_setup.i_preload_source ? cal_address1_value : PRELOAD_FIXED))
    else $error("i preload reference wrong");
  AST_OE_IDLE: assert property (csb_n [*6] |-> !sdio_oe)
    else $error("sdio driven outside frame");
  AST_OE_FRAME: assert property ($rose(sdio_oe) |-> !csb_n && $past(!csb_n, 8))
    else $error("sdio drive started early");
  AST_HOLD_IDLE: assert property (csb_n [*8] |-> $stable(aux_i) && $stable(aux_q)
    && $stable(reference_trim_code) && $stable({cal_clock_gate, cal_clock_divider}))
    else $error("register changed without a frame");
  AST_RESET_ZERO: assert property (disable iff (1'b0) $past(rst) && rst |-> aux_i == '0 && aux_q == '0
    && reference_trim_code == 6'h00 && !cal_clock && !sdio_oe && {cal_clock_gate, cal_clock_divider} == 4'h0
    && cal_setup == {4'h0, PRELOAD_FIXED, PRELOAD_FIXED})
    else $error("output not cleared by reset");
endmodule : dac_aux_cfg_monitor

// ### testbench/tb_top.sv
// Self-checking bench for the aux, reference and calibration slice.
// Drives the serial port pins itself; calibration memory value comes from the bench.
`timescale 1ns/1ps
module tb_top;
  import dac_aux_cfg_pkg::*;
  // Each sclk phase in sys_clk cycles; leaves room for the pin synchronisers
  localparam int P = 8;
  logic         sys_clk;
  logic         rst;
  logic         csb_n;
  logic         sclk;
  logic         sdio_in;
  logic         sdio_out;
  logic         sdio_oe;
  logic [5:0]   cal_address1_value;
  aux_channel_s aux_i;
  aux_channel_s aux_q;
  logic [5:0]   reference_trim_code;
  cal_setup_s   cal_setup;
  logic         cal_clock_gate;
  logic [2:0]   cal_clock_divider;
  logic         cal_clock;
  logic [7:0]   exp_reg [6];
  logic [23:0]  rows [20];
  int           bad_count;
  int           checked;

  dac_aux_ref_cal_config_regs dac_aux_ref_cal_config_regs_inst
  (
    .sys_clk, .rst, .csb_n, .sclk, .sdio_in, .sdio_out, .sdio_oe, .cal_address1_value, .aux_i, .aux_q,
    .reference_trim_code, .cal_setup, .cal_clock_gate, .cal_clock_divider, .cal_clock
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // Read data is taken at the end of each low phase
  task automatic spi(input logic rw, input logic [4:0] a, input logic [7:0] d, input int nb, output logic [7:0] q);
    logic [15:0] f;
    f = {rw, 2'b00, a, d};
    q = 8'h00;
    @(posedge sys_clk) csb_n <= 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      sdio_in <= f[15-i];
      repeat (P) @(posedge sys_clk);
      if (i >= 8)
        q[15-i] = sdio_out;
      sclk <= 1'b1;
      repeat (P) @(posedge sys_clk);
      sclk <= 1'b0;
    end
    repeat (P) @(posedge sys_clk);
    csb_n <= 1'b1;
    repeat (P) @(posedge sys_clk);
  endtask : spi

  task automatic check_outs();
    logic [7:0] c;
    logic [5:0] rq;
    logic [5:0] ri;
    c  = exp_reg[5];
    rq = c[7] ? cal_address1_value : PRELOAD_FIXED;
    ri = c[6] ? cal_address1_value : PRELOAD_FIXED;
    cmp("aux_i", {exp_reg[1], exp_reg[0]}, aux_i);
    cmp("aux_i_span", 16'(exp_reg[1][6:5]), 16'(aux_i.span));
    cmp("aux_i_top", 16'(exp_reg[1][4:2]), 16'(aux_i.top_of_range));
    cmp("aux_i_level", {6'h00, exp_reg[1][1:0], exp_reg[0]}, 16'(aux_i.level_word));
    cmp("aux_q", {exp_reg[3], exp_reg[2]}, aux_q);
    cmp("aux_q_top", 16'(exp_reg[3][4:2]), 16'(aux_q.top_of_range));
    cmp("aux_q_enable", 16'(exp_reg[3][7]), 16'(aux_q.enable));
    cmp("aux_q_level", {6'h00, exp_reg[3][1:0], exp_reg[2]}, 16'(aux_q.level_word));
    cmp("trim", 16'(exp_reg[4][5:0]), 16'(reference_trim_code));
    cmp("cal_select", 16'(c[5:4]), 16'({cal_setup.q_selfcal_select, cal_setup.i_selfcal_select}));
    cmp("cal_setup", {c[7:4], rq, ri}, cal_setup);
    cmp("i_preload", 16'(ri), 16'(cal_setup.i_preload_reference));
    cmp("cal_gate", 16'(c[3]), 16'(cal_clock_gate));
    cmp("cal_div", 16'(c[2:0]), 16'(cal_clock_divider));
  endtask : check_outs

  task automatic wait_rise(output int n);
    logic p;
    n = 0;
    p = cal_clock;
    repeat (600)
    begin
      @(posedge sys_clk);
      n++;
      if (p === 1'b0 && cal_clock === 1'b1)
        break;
      p = cal_clock;
    end
  endtask : wait_rise

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    int n;
    logic [7:0] q;
    rst = 1'b1;
    csb_n = 1'b1;
    sclk = 1'b0;
    sdio_in = 1'b0;
    cal_address1_value = 6'h00;
    bad_count = 0;
    checked = 0;
    foreach (exp_reg[k]) exp_reg[k] = 8'h00;
    // Columns: address, write data, expected read back
    rows = '{24'h09_ffff, 24'h0a_0303, 24'h0a_2727, 24'h0a_c8c8, 24'h0a_6c6c, 24'h0a_1010, 24'h0b_0000,
             24'h0c_0202, 24'h0c_8080, 24'h0c_a7a7, 24'h0c_c8c8, 24'h0c_eeee, 24'h0c_1010, 24'h0d_1f1f,
             24'h0d_2020, 24'h0d_3f3f, 24'h0d_ff3f, 24'h0e_c0c0, 24'h0e_3030, 24'h0e_0000};
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    check_outs();
    for (int i = 0; i < 20; i++)
    begin
      spi(1'b0, rows[i][20:16], rows[i][15:8], 16, q);
      exp_reg[int'(rows[i][20:16]) - 9] = rows[i][7:0];
      check_outs();
      spi(1'b1, rows[i][20:16], 8'h00, 16, q);
      cmp("readback", 16'(rows[i][7:0]), 16'(q));
    end
    // Unmapped place, aborted frame, then a low byte on its own
    spi(1'b0, 5'h1f, 8'h55, 16, q);
    spi(1'b1, 5'h1f, 8'h00, 16, q);
    cmp("unmapped", 16'h0000, 16'(q));
    spi(1'b0, ADDR_AUX_Q_LEVEL_LOW, 8'haa, 12, q);
    check_outs();
    spi(1'b0, ADDR_AUX_Q_LEVEL_LOW, 8'h5a, 16, q);
    exp_reg[2] = 8'h5a;
    check_outs();
    // User preload follows the calibration memory value
    spi(1'b0, ADDR_CALIBRATION_CTRL, 8'hc0, 16, q);
    exp_reg[5] = 8'hc0;
    cal_address1_value <= 6'h15;
    repeat (4) @(posedge sys_clk);
    check_outs();
    cal_address1_value <= 6'h2a;
    repeat (4) @(posedge sys_clk);
    check_outs();
    // Every divider code with the gate on
    for (int i = 0; i < 8; i++)
    begin
      spi(1'b0, ADDR_CALIBRATION_CTRL, 8'h08 | 8'(i), 16, q);
      wait_rise(n);
      wait_rise(n);
      cmp("cal_period", 16'(256 >> i), 16'(n));
    end
    spi(1'b0, ADDR_CALIBRATION_CTRL, 8'h07, 16, q);
    exp_reg[5] = 8'h07;
    repeat (20) @(posedge sys_clk);
    cmp("cal_clock_off", 16'h0000, 16'(cal_clock));
    check_outs();
    // Reset in mid-run clears everything
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (exp_reg[k]) exp_reg[k] = 8'h00;
    repeat (5) @(posedge sys_clk);
    check_outs();
    spi(1'b1, ADDR_AUX_Q_CONTROL, 8'h00, 16, q);
    cmp("reset_readback", 16'h0000, 16'(q));
    end_sim();
  end

  // Run needs about 16000 cycles
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    bad_count++;
    end_sim();
  end
endmodule : tb_top

bind dac_aux_ref_cal_config_regs dac_aux_cfg_monitor dac_aux_cfg_monitor_inst
(
  .sys_clk, .rst, .csb_n, .sdio_oe, .cal_address1_value, .aux_i, .aux_q, .reference_trim_code,
  .cal_setup, .cal_clock_gate, .cal_clock_divider, .cal_clock
);

// ### verilog/dac_aux_cfg_pkg.sv
// Shared constants and carrier types for the auxiliary, reference and calibration configuration slice.
// Assumes one system clock (sys_clk) and register access over the serial control port only.
package dac_aux_cfg_pkg;

  // ****************************************************************
  // Register offsets (5-bit serial port address space)
  // ****************************************************************
  localparam logic [4:0] ADDR_AUX_I_LEVEL_LOW   = 5'h09;
  localparam logic [4:0] ADDR_AUX_I_CONTROL     = 5'h0A;
  localparam logic [4:0] ADDR_AUX_Q_LEVEL_LOW   = 5'h0B;
  localparam logic [4:0] ADDR_AUX_Q_CONTROL     = 5'h0C;
  localparam logic [4:0] ADDR_REFERENCE_TRIM    = 5'h0D;
  localparam logic [4:0] ADDR_CALIBRATION_CTRL  = 5'h0E;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int AUX_ENABLE_BIT      = 7;
  localparam int AUX_SPAN_HI         = 6;
  localparam int AUX_SPAN_LO         = 5;
  localparam int AUX_TOP_HI          = 4;
  localparam int AUX_TOP_LO          = 2;
  localparam int AUX_LEVEL_MSB_HI    = 1;
  localparam int AUX_LEVEL_MSB_LO    = 0;
  localparam int TRIM_HI             = 5;
  localparam int CAL_Q_PRELOAD_BIT   = 7;
  localparam int CAL_I_PRELOAD_BIT   = 6;
  localparam int CAL_Q_SELECT_BIT    = 5;
  localparam int CAL_I_SELECT_BIT    = 4;
  localparam int CAL_GATE_BIT        = 3;
  localparam int CAL_DIV_HI          = 2;
  localparam int CAL_DIV_LO          = 0;

  // ****************************************************************
  // Reset values and fixed codes
  // ****************************************************************
  localparam logic [7:0] RESET_LEVEL_LOW        = 8'h00;
  localparam logic [7:0] RESET_AUX_CONTROL      = 8'h00;
  localparam logic [5:0] RESET_TRIM             = 6'h00;
  localparam logic [7:0] RESET_CAL_CONTROL      = 8'h00;
  localparam logic [7:0] READ_UNMAPPED          = 8'h00;
  localparam logic [5:0] PRELOAD_FIXED          = 6'h20;
  // Half period in DAC clocks for divide by 256; each code step halves it
  localparam logic [7:0] CAL_HALF_PERIOD_MAX    = 8'h80;

  // ****************************************************************
  // Serial port framing
  // ****************************************************************
  localparam logic [4:0] SPI_INSTR_BITS         = 5'h08;
  localparam logic [4:0] SPI_FRAME_BITS         = 5'h10;
  localparam int         SPI_RW_BIT             = 7;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic       enable;
    logic [1:0] span;
    logic [2:0] top_of_range;
    logic [9:0] level_word;
  } aux_channel_s;

  typedef struct packed {
    logic       wr_en;
    logic [4:0] addr;
    logic [7:0] wdata;
  } reg_write_s;

  typedef struct packed {
    logic       q_preload_source;
    logic       i_preload_source;
    logic       q_selfcal_select;
    logic       i_selfcal_select;
    logic [5:0] q_preload_reference;
    logic [5:0] i_preload_reference;
  } cal_setup_s;

endpackage : dac_aux_cfg_pkg

// ### verilog/dac_aux_ref_cal_config_regs.sv
// Auxiliary output, reference trim and calibration control registers of a dual converter.
// Assumes the serial port pins are asynchronous to sys_clk, which is the DAC clock.
`timescale 1ns/1ps
module dac_aux_ref_cal_config_regs
(
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic                         csb_n,
  input  wire logic                         sclk,
  input  wire logic                         sdio_in,
  output logic                              sdio_out,
  output logic                              sdio_oe,
  input  wire logic [5:0]                   cal_address1_value,
  output dac_aux_cfg_pkg::aux_channel_s     aux_i,
  output dac_aux_cfg_pkg::aux_channel_s     aux_q,
  output logic [5:0]                        reference_trim_code,
  output dac_aux_cfg_pkg::cal_setup_s       cal_setup,
  output logic                              cal_clock_gate,
  output logic [2:0]                        cal_clock_divider,
  output logic                              cal_clock
);
  import dac_aux_cfg_pkg::*;

  // ****************************************************************
  // Serial control port
  // ****************************************************************
  logic [4:0]  rd_addr;
  logic [7:0]  rd_data;
  reg_write_s  wr;

  serial_port_slave u_port
  (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .csb_n    (csb_n),
    .sclk     (sclk),
    .sdio_in  (sdio_in),
    .sdio_out (sdio_out),
    .sdio_oe  (sdio_oe),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data),
    .wr       (wr)
  );

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] aux_i_level_low;
  logic [7:0] aux_i_control;
  logic [7:0] aux_q_level_low;
  logic [7:0] aux_q_control;
  logic [5:0] reference_trim;
  logic [7:0] calibration_control;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      aux_i_level_low <= RESET_LEVEL_LOW;
      aux_i_control   <= RESET_AUX_CONTROL;
    end
    else if (wr.wr_en)
    begin
      if (wr.addr == ADDR_AUX_I_LEVEL_LOW)
        aux_i_level_low <= wr.wdata;
      if (wr.addr == ADDR_AUX_I_CONTROL)
        aux_i_control <= wr.wdata;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      aux_q_level_low <= RESET_LEVEL_LOW;
      aux_q_control   <= RESET_AUX_CONTROL;
    end
    else if (wr.wr_en)
    begin
      if (wr.addr == ADDR_AUX_Q_LEVEL_LOW)
        aux_q_level_low <= wr.wdata;
      if (wr.addr == ADDR_AUX_Q_CONTROL)
        aux_q_control <= wr.wdata;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      reference_trim <= RESET_TRIM;
    else if (wr.wr_en && wr.addr == ADDR_REFERENCE_TRIM)
      reference_trim <= wr.wdata[TRIM_HI:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      calibration_control <= RESET_CAL_CONTROL;
    else if (wr.wr_en && wr.addr == ADDR_CALIBRATION_CTRL)
      calibration_control <= wr.wdata;
  end

  // ****************************************************************
  // Read back
  // ****************************************************************
  // read last written, except trim bits 7:6 read as zero
  always_comb
  begin
    case (rd_addr)
      ADDR_AUX_I_LEVEL_LOW:  rd_data = aux_i_level_low;
      ADDR_AUX_I_CONTROL:    rd_data = aux_i_control;
      ADDR_AUX_Q_LEVEL_LOW:  rd_data = aux_q_level_low;
      ADDR_AUX_Q_CONTROL:    rd_data = aux_q_control;
      // Reserved bits 7:6 read as zero
      ADDR_REFERENCE_TRIM:   rd_data = {2'b00, reference_trim};
      ADDR_CALIBRATION_CTRL: rd_data = calibration_control;
      default:               rd_data = READ_UNMAPPED;
    endcase
  end

  // ****************************************************************
  // Analog control outputs
  // ****************************************************************
  // Registered so the analog controls never see decode glitches
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      aux_i               <= '0;
      aux_q               <= '0;
      reference_trim_code <= RESET_TRIM;
    end
    else
    begin
      aux_i.enable        <= aux_i_control[AUX_ENABLE_BIT];
      aux_i.span          <= aux_i_control[AUX_SPAN_HI:AUX_SPAN_LO];
      aux_i.top_of_range  <= aux_i_control[AUX_TOP_HI:AUX_TOP_LO];
      aux_i.level_word    <= {aux_i_control[AUX_LEVEL_MSB_HI:AUX_LEVEL_MSB_LO], aux_i_level_low};
      aux_q.enable        <= aux_q_control[AUX_ENABLE_BIT];
      aux_q.span          <= aux_q_control[AUX_SPAN_HI:AUX_SPAN_LO];
      aux_q.top_of_range  <= aux_q_control[AUX_TOP_HI:AUX_TOP_LO];
      aux_q.level_word    <= {aux_q_control[AUX_LEVEL_MSB_HI:AUX_LEVEL_MSB_LO], aux_q_level_low};
      reference_trim_code <= reference_trim;
    end
  end

  // ****************************************************************
  // Calibration setup
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cal_setup         <= '0;
      // fixed preload in reset
      // Source bits are cleared, so the references must already show the fixed value
      cal_setup.q_preload_reference <= PRELOAD_FIXED;
      cal_setup.i_preload_reference <= PRELOAD_FIXED;
      cal_clock_gate    <= 1'b0;
      cal_clock_divider <= '0;
    end
    else
    begin
      cal_setup.q_preload_source <= calibration_control[CAL_Q_PRELOAD_BIT];
      cal_setup.i_preload_source <= calibration_control[CAL_I_PRELOAD_BIT];
      cal_setup.q_selfcal_select <= calibration_control[CAL_Q_SELECT_BIT];
      cal_setup.i_selfcal_select <= calibration_control[CAL_I_SELECT_BIT];
      cal_setup.q_preload_reference <= calibration_control[CAL_Q_PRELOAD_BIT] ? cal_address1_value
                                                                                : PRELOAD_FIXED;
      cal_setup.i_preload_reference <= calibration_control[CAL_I_PRELOAD_BIT] ? cal_address1_value
                                                                                : PRELOAD_FIXED;
      cal_clock_gate    <= calibration_control[CAL_GATE_BIT];
      cal_clock_divider <= calibration_control[CAL_DIV_HI:CAL_DIV_LO];
    end
  end

  // ****************************************************************
  // Calibration clock divider
  // ****************************************************************
  // Codes 000 to 111 give divide by 256 down to divide by 2
  logic [7:0] half_period;
  logic [7:0] div_count;
  logic [7:0] terminal_count;

  assign half_period    = CAL_HALF_PERIOD_MAX >> calibration_control[CAL_DIV_HI:CAL_DIV_LO];
  assign terminal_count = half_period - 8'h01;

  always_ff @(posedge sys_clk)
  begin
    if (rst || !calibration_control[CAL_GATE_BIT])
    begin
      div_count <= '0;
      cal_clock <= 1'b0;
    end
    else if (div_count >= terminal_count)
    begin
      // >= so a smaller ratio written mid-count wraps at once
      div_count <= '0;
      cal_clock <= ~cal_clock;
    end
    else
      div_count <= div_count + 8'h01;
  end

endmodule : dac_aux_ref_cal_config_regs

// ### verilog/serial_port_slave.sv
// Three-wire serial control port slave: 16-bit frames, instruction byte then one data byte.
// Assumes sclk is slow against sys_clk (each sclk phase at least six sys_clk periods).
`timescale 1ns/1ps
module serial_port_slave
(
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic                         csb_n,
  input  wire logic                         sclk,
  input  wire logic                         sdio_in,
  output logic                              sdio_out,
  output logic                              sdio_oe,
  output logic [4:0]                        rd_addr,
  input  wire logic [7:0]                   rd_data,
  output dac_aux_cfg_pkg::reg_write_s       wr
);
  import dac_aux_cfg_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Stage 0 is the first flop; only stage 1 reads it
  logic [2:0] s0;
  logic [2:0] s1;
  logic [2:0] s2;
  logic [2:0] filt;
  logic [2:0] filt_d;

  always_ff @(posedge sys_clk)
  begin
    s0 <= {csb_n, sclk, sdio_in};
    s1 <= s0;
    s2 <= s1;
  end

  // A change counts once stages 1 and 2 agree
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_filt
      always_ff @(posedge sys_clk)
      begin
        if (rst)
          filt[g] <= (g == 2) ? 1'b1 : 1'b0;
        else if (s1[g] == s2[g])
          filt[g] <= s2[g];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      filt_d <= 3'b100;
    else
      filt_d <= filt;
  end

  logic csb_q;
  logic sclk_rise;
  logic sclk_fall;
  assign csb_q     = filt[2];
  assign sclk_rise = filt[1] & ~filt_d[1] & ~csb_q;
  assign sclk_fall = ~filt[1] & filt_d[1] & ~csb_q;

  // ****************************************************************
  // Frame shifter
  // ****************************************************************
  logic [4:0]  bit_cnt;
  logic [15:0] in_shift;
  logic [7:0]  out_shift;
  logic        reading;
  logic [15:0] next_in_shift;

  assign next_in_shift = {in_shift[14:0], filt[0]};
  assign rd_addr       = in_shift[4:0];

  always_ff @(posedge sys_clk)
  begin
    if (rst || csb_q)
    begin
      bit_cnt  <= '0;
      in_shift <= '0;
      reading  <= 1'b0;
      wr       <= '0;
    end
    else
    begin
      wr.wr_en <= 1'b0;
      // Bits past the first frame are ignored until chip select rises
      if (sclk_rise && bit_cnt < SPI_FRAME_BITS)
      begin
        in_shift <= next_in_shift;
        bit_cnt  <= bit_cnt + 5'h01;
        if (bit_cnt == SPI_INSTR_BITS - 5'h01)
          reading <= next_in_shift[SPI_RW_BIT];
        if (bit_cnt == SPI_FRAME_BITS - 5'h01 && !reading)
        begin
          wr.wr_en <= 1'b1;
          wr.addr  <= next_in_shift[12:8];
          wr.wdata <= next_in_shift[7:0];
        end
      end
    end
  end

  // Read data is captured once the address is complete, then shifted on falling edges
  always_ff @(posedge sys_clk)
  begin
    if (rst || csb_q)
    begin
      out_shift <= '0;
      sdio_out  <= 1'b0;
      sdio_oe   <= 1'b0;
    end
    else if (reading && bit_cnt == SPI_INSTR_BITS && !sdio_oe && sclk_fall)
    begin
      sdio_out  <= rd_data[7];
      out_shift <= {rd_data[6:0], 1'b0};
      sdio_oe   <= 1'b1;
    end
    else if (sdio_oe && sclk_fall)
    begin
      sdio_out  <= out_shift[7];
      out_shift <= {out_shift[6:0], 1'b0};
      sdio_oe   <= (bit_cnt < SPI_FRAME_BITS);
    end
  end

endmodule : serial_port_slave
